//--- src/pio_consts.svh
// Constants for the programmed I/O peripheral port.
// Assumes inclusion by the package and the port logic only.
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH
`define PIO_DATA_W        12
`define PIO_DEV_W         6
`define PIO_OP_W          3
`define PIO_DEV_LSB       3
`define PIO_OP_LSB        9
`define PIO_DEV_CODE      6'h30
`define PIO_OP_SKIP_BIT   0
`define PIO_OP_IN_BIT     1
`define PIO_OP_OUT_BIT    2
`define PIO_CLK_NS        10
`define PIO_INIT_NS       600
`define PIO_INIT_MIN_CYC  ((`PIO_INIT_NS / 2 + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`define PIO_CTL_READ      3'h0
`define PIO_CTL_JAM_IN    3'h3
`define PIO_CTL_OR_IN     3'h1
`define PIO_CTL_SKIP_PC   3'h4
// Idle levels of window, pulse, strobe, run and initialize, in sync order
`define PIO_SYNC_CTL_IDLE 5'h16
`endif

//--- src/pio_pkg.sv
// Types shared by the programmed I/O peripheral port.
// Assumes pio_consts.svh is reachable by bare name.
`default_nettype none
`include "pio_consts.svh"
package pio_pkg;
    // Twelve-bit word on the shared data lines
    typedef logic [`PIO_DATA_W-1:0] pio_word_t;
    // Transfer phase within one window
    typedef enum logic [1:0] {PIO_IDLE, PIO_SEL, PIO_DONE} pio_phase_t;
endpackage
`default_nettype wire

//--- src/pio_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to the sampling clock.
`default_nettype none
module pio_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Asynchronous in, synchronised out
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;   // First stage, read only by the second
    logic [W-1:0] meta_nxt; // Next first stage
    logic [W-1:0] sync_r;   // Second stage
    logic [W-1:0] sync_nxt; // Next second stage

    // Next values: shift the pins through
    always_comb begin
        meta_nxt = d_i;
        sync_nxt = meta_r;
    end

    // Registers take the pins' idle levels under reset, so no false edge follows
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign q_o = sync_r;
endmodule
`default_nettype wire

//--- src/pio_port.sv
// Peripheral end of the programmed I/O backplane bus.
// Assumes the processor drives the window, time pulses, run and
// initialize; all bus inputs are asynchronous to CLK_SYS_I.
// Notes on behaviour
// - Decode only inside the transfer window
// - Third time pulse clears flag, loads buffer on output
// - Selected device pulls indicator line low
// - Twelve shared bidirectional data lines
// - Device drives transfer-control lines 0 and 1 for input, never line 2
// - Flag set on test pulls branch line
// - Service request low while data waits
// - Hold more-pending low until final strobe
// - Initialize pulse clears flag
`default_nettype none
`include "pio_consts.svh"
module pio_port
    import pio_pkg::*;
#(
    parameter logic [`PIO_DEV_W-1:0] DEV_CODE  = `PIO_DEV_CODE,
    parameter int                    XFER_CNT  = 1
) (
    // System clock and reset
    input  wire logic      CLK_SYS_I,
    input  wire logic      RST_N_I,
    // Instruction and timing from the processor
    input  wire pio_pkg::pio_word_t MEMORY_DATA_LINES_I,
    input  wire logic      IO_PAUSE_N_I,
    input  wire logic      THIRD_TIME_PULSE_I,
    input  wire logic      LOAD_STROBE_N_I,
    input  wire logic      RUN_N_I,
    input  wire logic      INITIALIZE_I,
    // Shared data lines, open-drain style
    input  wire pio_pkg::pio_word_t DATA_LINES_I,
    output var  pio_pkg::pio_word_t DATA_LINES_O,
    output var  pio_pkg::pio_word_t DATA_LINES_OE_N_O,
    // Open-drain control responses, low enable drives
    output var  logic      INTERNAL_IO_N_O,
    output var  logic      INTERNAL_IO_OE_N_O,
    output var  logic [2:0] TRANSFER_CONTROL_LINES_O,
    output var  logic [2:0] TRANSFER_CONTROL_LINES_OE_N_O,
    output var  logic      BRANCH_OVER_N_O,
    output var  logic      BRANCH_OVER_OE_N_O,
    output var  logic      SERVICE_REQUEST_N_O,
    output var  logic      SERVICE_REQUEST_OE_N_O,
    output var  logic      MORE_TRANSFERS_PENDING_N_O,
    output var  logic      MORE_TRANSFERS_PENDING_OE_N_O,
    // User side
    input  wire logic      USER_DATA_READY_I,
    input  wire pio_pkg::pio_word_t USER_DATA_I,
    output var  pio_pkg::pio_word_t USER_OUT_WORD_O,
    output var  logic      USER_OUT_STROBE_O,
    output var  logic      FLAG_O,
    output var  logic      RUNNING_O
);
    localparam int NSYNC = `PIO_DATA_W * 2 + 5;
    // Idle bus levels: no codes, data lines pulled high, controls released
    localparam logic [NSYNC-1:0] SYNC_IDLE = {{`PIO_DATA_W{1'h0}}, {`PIO_DATA_W{1'h1}},
                                              `PIO_SYNC_CTL_IDLE};

    // Synchronised bus inputs
    logic [NSYNC-1:0] raw_in;   // Pins gathered for the synchroniser
    logic [NSYNC-1:0] sync_in;  // Pins after two flip-flops
    pio_word_t        md_s;     // Instruction word
    pio_word_t        data_s;   // Data lines
    logic             pause_n_s;// Transfer window, low active
    logic             tp3_s;    // Third time pulse
    logic             strobe_n_s;// Register load strobe
    logic             run_n_s;  // Executing line
    logic             init_s;   // Initialize pulse

    assign raw_in = {MEMORY_DATA_LINES_I, DATA_LINES_I, IO_PAUSE_N_I,
                     THIRD_TIME_PULSE_I, LOAD_STROBE_N_I, RUN_N_I, INITIALIZE_I};

    // Every bus input crosses by two flip-flops
    pio_sync #(.W(NSYNC), .RST_VAL(SYNC_IDLE)) u_sync (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .d_i     (raw_in),
        .q_o     (sync_in)
    );

    assign {md_s, data_s, pause_n_s, tp3_s, strobe_n_s, run_n_s, init_s} = sync_in;

    // Decoded fields of the instruction word
    logic [`PIO_DEV_W-1:0] dev_code;  // Device select field
    logic [`PIO_OP_W-1:0]  op_code;   // Operation select field
    logic                  selected;  // This device, inside the window

    // The processor places the codes on fixed bit fields
    // fields by position
    assign dev_code = md_s[`PIO_DEV_LSB +: `PIO_DEV_W];
    assign op_code  = md_s[`PIO_OP_LSB  +: `PIO_OP_W];
    assign selected = !pause_n_s && (dev_code == DEV_CODE);

    // Protocol state
    logic       flag_r,   flag_nxt;    // Device flag
    logic       tp3_d_r,  tp3_d_nxt;   // Last pulse level, for edges
    logic       stb_d_r,  stb_d_nxt;   // Last strobe level, for edges
    pio_word_t  obuf_r,   obuf_nxt;    // Output buffer register
    pio_word_t  ibuf_r,   ibuf_nxt;    // Input buffer register
    logic       ostb_r,   ostb_nxt;    // One-cycle new-word pulse
    logic [7:0] left_r,   left_nxt;    // Strobes still to come
    pio_phase_t phase_r,  phase_nxt;   // Window phase
    logic       tp3_rise;              // Third pulse leading edge
    logic       stb_fall;              // Load strobe leading edge

    assign tp3_rise = tp3_s && !tp3_d_r;
    assign stb_fall = !strobe_n_s && stb_d_r;

    // Next-state logic for flag, buffers and window tracking
    always_comb begin
        tp3_d_nxt = tp3_s;
        stb_d_nxt = strobe_n_s;
        flag_nxt  = flag_r;
        obuf_nxt  = obuf_r;
        ibuf_nxt  = ibuf_r;
        ostb_nxt  = 1'b0;
        left_nxt  = left_r;
        phase_nxt = phase_r;
        if (USER_DATA_READY_I) begin
            flag_nxt = 1'b1;
            ibuf_nxt = USER_DATA_I;
        end
        // Set wins over a clear by this pulse; initialize comes last and wins over both
        if (selected && tp3_rise) begin
            flag_nxt = USER_DATA_READY_I;
            if (op_code[`PIO_OP_OUT_BIT]) begin
                obuf_nxt = data_s;
                ostb_nxt = 1'b1;
            end
        end
        if (init_s) begin
            flag_nxt = 1'b0;
        end
        case (phase_r)
            // Waiting for the window to open on this device
            PIO_IDLE: begin
                if (selected) begin
                    phase_nxt = PIO_SEL;
                    left_nxt  = 8'(XFER_CNT);
                end
            end
            // Count strobes so the last one is let through
            PIO_SEL: begin
                if (stb_fall && left_r != 8'h00) begin
                    left_nxt = left_r - 8'h01;
                end
                if (pause_n_s) begin
                    phase_nxt = PIO_IDLE;
                end
            end
            default: begin
                phase_nxt = PIO_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flag_r  <= 1'b0;
            tp3_d_r <= 1'b0;
            stb_d_r <= 1'b1;
            obuf_r  <= '0;
            ibuf_r  <= '0;
            ostb_r  <= 1'b0;
            left_r  <= 8'h00;
            phase_r <= PIO_IDLE;
        end else begin
            flag_r  <= flag_nxt;
            tp3_d_r <= tp3_d_nxt;
            stb_d_r <= stb_d_nxt;
            obuf_r  <= obuf_nxt;
            ibuf_r  <= ibuf_nxt;
            ostb_r  <= ostb_nxt;
            left_r  <= left_nxt;
            phase_r <= phase_nxt;
        end
    end

    // Bus response terms
    logic drive_in;   // Place input word on data lines
    logic pending;    // More strobes to follow
    logic [2:0] ctl;  // Transfer-control pattern

    // Input is driven only for an input operation while selected
    // shared data lines
    assign drive_in = selected && op_code[`PIO_OP_IN_BIT];
    assign pending  = selected && (phase_r == PIO_SEL) && (left_r > 8'h01);

    // Control lines tell the processor where the data goes
    // choose transfer path
    always_comb begin
        ctl = `PIO_CTL_READ;
        if (drive_in) begin
            ctl = `PIO_CTL_JAM_IN;
        end
    end

    // Open-drain drivers: a line pulled low has its enable low
    always_comb begin
        DATA_LINES_O                  = ibuf_r;
        DATA_LINES_OE_N_O             = drive_in ? '0 : '1;
        INTERNAL_IO_N_O               = 1'b0;
        INTERNAL_IO_OE_N_O            = !selected;
        TRANSFER_CONTROL_LINES_O      = 3'h0;
        TRANSFER_CONTROL_LINES_OE_N_O = selected ? ~ctl : 3'h7;
        BRANCH_OVER_N_O               = 1'b0;
        BRANCH_OVER_OE_N_O            = !(selected && op_code[`PIO_OP_SKIP_BIT] && flag_r);
        SERVICE_REQUEST_N_O           = 1'b0;
        SERVICE_REQUEST_OE_N_O        = !flag_r;
        MORE_TRANSFERS_PENDING_N_O    = 1'b0;
        MORE_TRANSFERS_PENDING_OE_N_O = !pending;
    end

    // User side outputs come from registers
    assign USER_OUT_WORD_O   = obuf_r;
    assign USER_OUT_STROBE_O = ostb_r;
    assign FLAG_O            = flag_r;
    assign RUNNING_O         = !run_n_s;
endmodule
`default_nettype wire

//--- dv/pio_port_monitor.sv
// Pin checker bound into each pio_port.
// Assumes the two-flop input sync and one strobe per transfer.
`default_nettype none
module pio_port_monitor
    import pio_pkg::*;
#(
    parameter int XFER_CNT = 1
) (
    // Clock, reset, processor pins and data line enables
    input wire logic CLK_SYS_I, RST_N_I, IO_PAUSE_N_I, THIRD_TIME_PULSE_I, INITIALIZE_I,
    input wire pio_pkg::pio_word_t MEMORY_DATA_LINES_I, DATA_LINES_OE_N_O,
    // Device responses
    input wire logic INTERNAL_IO_OE_N_O, BRANCH_OVER_N_O, BRANCH_OVER_OE_N_O, FLAG_O,
    input wire logic SERVICE_REQUEST_N_O, SERVICE_REQUEST_OE_N_O, USER_OUT_STROBE_O,
    input wire logic MORE_TRANSFERS_PENDING_OE_N_O,
    input wire logic [2:0] TRANSFER_CONTROL_LINES_O, TRANSFER_CONTROL_LINES_OE_N_O
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);
    // Sync delay is two flops, so the window is looked up two or three edges back
    property p_win;
        !INTERNAL_IO_OE_N_O |-> !$past(IO_PAUSE_N_I, 2) || !$past(IO_PAUSE_N_I, 3);
    endproperty
    a_win: assert property (p_win) else $error("selected without window");
    property p_ctl;
        !TRANSFER_CONTROL_LINES_OE_N_O[0] |-> !INTERNAL_IO_OE_N_O && TRANSFER_CONTROL_LINES_O == 3'h0;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control line while idle");
    property p_data;
        DATA_LINES_OE_N_O != 12'hFFF |-> TRANSFER_CONTROL_LINES_OE_N_O == 3'h4;
    endproperty
    a_data: assert property (p_data) else $error("data driven without input pattern");
    property p_skip;
        !BRANCH_OVER_OE_N_O |-> FLAG_O && !INTERNAL_IO_OE_N_O && !BRANCH_OVER_N_O;
    endproperty
    a_skip: assert property (p_skip) else $error("branch line without flag");
    property p_srq;
        (SERVICE_REQUEST_OE_N_O | SERVICE_REQUEST_N_O) == !FLAG_O;
    endproperty
    a_srq: assert property (p_srq) else $error("request line not following flag");
    property p_tp3;
        $rose(THIRD_TIME_PULSE_I) && !INTERNAL_IO_OE_N_O && MEMORY_DATA_LINES_I[11]
            |-> ##[2:5] USER_OUT_STROBE_O;
    endproperty
    a_tp3: assert property (p_tp3) else $error("no buffer load after pulse");
    property p_init;
        INITIALIZE_I [*5] |-> !FLAG_O;
    endproperty
    a_init: assert property (p_init) else $error("flag survives initialize");
    property p_more;
        !MORE_TRANSFERS_PENDING_OE_N_O |-> XFER_CNT > 1 && !INTERNAL_IO_OE_N_O;
    endproperty
    a_more: assert property (p_more) else $error("pending line on last strobe");
endmodule
bind pio_port pio_port_monitor #(.XFER_CNT(XFER_CNT)) u_mon (.*);
`default_nettype wire

//--- dv/pio_cpu_model.sv
// Behavioural processor driving the backplane I/O bus.
// Assumes the bench resolves the open-drain wires it reads back.
`default_nettype none
module pio_cpu_model
    import pio_pkg::*;
(
    input  wire logic               lclk_i,              // 125 ns processor timebase
    input  wire pio_pkg::pio_word_t data_w_i,            // resolved data lines
    input  wire logic               skip_n_i,            // resolved branch line
    output var  pio_pkg::pio_word_t md_o   = 12'h000,
    output var  pio_pkg::pio_word_t data_o = 12'hFFF,    // released lines float high
    output var  logic               pause_n_o = 1'b1,
    output var  logic               tp3_o = 1'b0,
    output var  logic               stb_n_o = 1'b1,
    output var  logic               run_n_o = 1'b0,      // running all along
    output var  logic               init_o = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    pio_word_t acc       = 12'h000;                      // accumulator after last strobe
    logic      skip_seen = 1'b0;                         // branch line before the pulse
    // One transfer; codes inside the window
    task automatic io_cycle(input logic [5:0] dev, input logic [2:0] op, input pio_word_t wr);
        @(posedge lclk_i);
        md_o = {op, dev, 3'h0};
        data_o = op[2] ? wr : 12'hFFF;
        pause_n_o = 1'b0;
        repeat (2) @(posedge lclk_i);
        skip_seen = !skip_n_i;
        // time state opened 250 ns before a 100 ns pulse
        tp3_o = 1'b1;
        #100 tp3_o = 1'b0;
        @(posedge lclk_i);
        stb_n_o = 1'b0;
        acc = data_w_i;
        @(posedge lclk_i);
        stb_n_o = 1'b1;
        pause_n_o = 1'b1;
        data_o = 12'hFFF;
        md_o = ~md_o;                                    // stale codes must not select
    endtask
    task automatic init_pulse();
        init_o = 1'b1;
        #600 init_o = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- dv/pio_port_bench.sv
// Self-checking bench: pio_port against the processor model.
// Assumes package, port, sync, model and monitor compile first.
`default_nettype none
module pio_port_bench
    import pio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [5:0] DEV = 6'h30;                  // code given to the port
    logic CLK_SYS_I, RST_N_I, USER_DATA_READY_I, lclk, skip_n;
    logic IO_PAUSE_N_I, THIRD_TIME_PULSE_I, LOAD_STROBE_N_I, RUN_N_I, INITIALIZE_I;
    logic INTERNAL_IO_N_O, INTERNAL_IO_OE_N_O, BRANCH_OVER_N_O, BRANCH_OVER_OE_N_O;
    logic SERVICE_REQUEST_N_O, SERVICE_REQUEST_OE_N_O, MORE_TRANSFERS_PENDING_N_O;
    logic MORE_TRANSFERS_PENDING_OE_N_O, USER_OUT_STROBE_O, FLAG_O, RUNNING_O;
    logic [2:0] TRANSFER_CONTROL_LINES_O, TRANSFER_CONTROL_LINES_OE_N_O;
    pio_word_t MEMORY_DATA_LINES_I, DATA_LINES_I, DATA_LINES_O, DATA_LINES_OE_N_O;
    pio_word_t USER_DATA_I, USER_OUT_WORD_O, cpu_data;
    int fail_count = 0;
    int check_count = 0;
    // Wired-AND with pull-ups: a released line reads high
    assign DATA_LINES_I = cpu_data & (DATA_LINES_OE_N_O | DATA_LINES_O);
    assign skip_n = BRANCH_OVER_OE_N_O | BRANCH_OVER_N_O;
    pio_port #(.DEV_CODE(DEV), .XFER_CNT(1)) dut (.*);
    pio_cpu_model cpu (.lclk_i(lclk), .data_w_i(DATA_LINES_I), .skip_n_i(skip_n),
        .md_o(MEMORY_DATA_LINES_I), .data_o(cpu_data), .pause_n_o(IO_PAUSE_N_I),
        .tp3_o(THIRD_TIME_PULSE_I), .stb_n_o(LOAD_STROBE_N_I), .run_n_o(RUN_N_I),
        .init_o(INITIALIZE_I));
    initial begin
        CLK_SYS_I = 1'b0;
        forever #5 CLK_SYS_I = ~CLK_SYS_I;
    end
    // Processor timebase, unrelated in phase
    initial begin
        lclk = 1'b0;
        #3.3;
        forever #62.5 lclk = ~lclk;
    end
    task automatic chk(input pio_word_t got, input pio_word_t exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hand the port a word and raise its flag
    task automatic set_flag(input pio_word_t w);
        @(posedge CLK_SYS_I);
        #1 USER_DATA_I = w;
        USER_DATA_READY_I = 1'b1;
        @(posedge CLK_SYS_I);
        #1 USER_DATA_READY_I = 1'b0;
        repeat (3) @(posedge CLK_SYS_I);
    endtask
    // Sample the selection responses well inside the window
    task automatic mid_window(input logic exp_sel, input logic [2:0] exp_ctl);
        repeat (25) @(posedge CLK_SYS_I);
        #1;
        chk(INTERNAL_IO_OE_N_O | INTERNAL_IO_N_O, !exp_sel, "indicator");
        chk(TRANSFER_CONTROL_LINES_OE_N_O, exp_ctl, "control lines");
        chk(MORE_TRANSFERS_PENDING_OE_N_O, 1'b1, "more pending");
    endtask
    task automatic t_output();
        int pulses = 0;
        set_flag(12'h111);
        chk(FLAG_O, 1'b1, "flag set");
        chk(SERVICE_REQUEST_OE_N_O | SERVICE_REQUEST_N_O, 1'b0, "request");
        fork
            cpu.io_cycle(DEV, 3'h4, 12'hA5C);
            mid_window(1'b1, 3'h7);
            for (int i = 0; i < 80; i++) begin
                @(posedge CLK_SYS_I);
                #1 pulses += USER_OUT_STROBE_O;
            end
        join
        chk(12'(pulses), 12'h001, "one out strobe");
        chk(USER_OUT_WORD_O, 12'hA5C, "out word");
        chk(FLAG_O, 1'b0, "flag cleared");
    endtask
    task automatic t_input();
        set_flag(12'h3C6);
        fork
            cpu.io_cycle(DEV, 3'h2, 12'h000);
            mid_window(1'b1, 3'h4);
        join
        chk(cpu.acc, 12'h3C6, "in word");
    endtask
    // Another device code must leave the lines released
    task automatic t_foreign();
        set_flag(12'h0F0);
        fork
            cpu.io_cycle(6'h31, 3'h2, 12'h000);
            mid_window(1'b0, 3'h7);
        join
        chk(cpu.acc, 12'hFFF, "foreign in");
        chk(FLAG_O, 1'b1, "flag kept");
    endtask
    task automatic t_skip();
        cpu.io_cycle(DEV, 3'h1, 12'h000);
        chk(cpu.skip_seen, 1'b1, "skip with flag");
        set_flag(12'h001);
        cpu.init_pulse();
        chk(FLAG_O, 1'b0, "init clears");
        cpu.io_cycle(DEV, 3'h1, 12'h000);
        chk(cpu.skip_seen, 1'b0, "skip without flag");
    endtask
    initial begin
        USER_DATA_READY_I = 1'b0;
        USER_DATA_I = 12'h000;
        RST_N_I = 1'b0;
        repeat (6) @(posedge CLK_SYS_I);
        chk(RUNNING_O, 1'b0, "not running in reset");
        #1 RST_N_I = 1'b1;
        repeat (3) @(posedge CLK_SYS_I);
        chk(FLAG_O, 1'b0, "reset flag");
        chk(RUNNING_O, 1'b1, "running");
        t_output();
        t_input();
        t_foreign();
        t_skip();
        report_and_stop();
    end
    // Cut a hang short
    initial begin
        #200000;
        fail_count++;
        $display("BAD t=%0t watchdog", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
